// *** core/fsp_mode_pkg.sv ***
// Constants shared by the device and controller ends.
// Assumes one 40 MHz clock and a synchronous active-low reset.
//
// What this block does
// - Control bit 0 set enters command bus training
// - Training with CKE low: ignore commands, echo CA
// - Controller raises CKE before clearing training bit
// - Control bit 1 enables read preamble training
// - Bit 2 outputs active set point reference levels
// - Bit 3 selects fast-settling reference generator
// - Option cleared: report 011b instead of 001b/010b
// - Option applies only when capability bit is one
// - Controller follows reported refresh code regardless; this controller has no refresh logic
// - Bit 5 zero masks writes, one disables
// - Controller issues no masked write when disabled
// - Bit 6 picks set point that writes update
// - Bit 7 picks set point governing operation
// - Control register resets to all zero
// - Level codes above 110010b are reserved
// - Data range bit: 0 range0, 1 range1 default
// - Reading data reference returns eight bits, zeros
// - Level write goes to write-selected set point
// - Range and level hold until rewrite or reset
// - Two copies; accesses reach write-selected copy only
// - Operation uses only the operate-selected copy
// - Controller writes range together with level
package fsp_mode_pkg;

    // Mode register addresses on the link
    localparam logic [5:0] ADDR_CAPABILITY   = 6'h00;
    localparam logic [5:0] ADDR_REFRESH_STAT = 6'h04;
    localparam logic [5:0] ADDR_OP_CONTROL   = 6'h0d;
    localparam logic [5:0] ADDR_DATA_REF     = 6'h0e;

    // Field positions of operating_point_control
    localparam int BIT_CMD_BUS_TRAIN  = 0;
    localparam int BIT_READ_PRE_TRAIN = 1;
    localparam int BIT_REF_LEVEL_OUT  = 2;
    localparam int BIT_REF_FAST       = 3;
    localparam int BIT_REFRESH_OPTION = 4;
    localparam int BIT_MASK_DISABLE   = 5;
    localparam int BIT_WRITE_SP_SEL   = 6;
    localparam int BIT_OPERATE_SP_SEL = 7;

    // Field positions of data_reference_level
    localparam int BIT_DATA_REF_RANGE = 6;

    // Reset values and highest legal level code
    localparam logic [7:0] OP_CONTROL_RESET = 8'h00;
    localparam logic [6:0] DATA_REF_RESET   = 7'h4d;
    localparam logic [5:0] LEVEL_CODE_MAX   = 6'h32;

    // Refresh status codes
    localparam logic [2:0] REFRESH_CODE_A   = 3'h1;
    localparam logic [2:0] REFRESH_CODE_B   = 3'h2;
    localparam logic [2:0] REFRESH_CODE_SUB = 3'h3;

    // Controller register byte addresses
    localparam logic [3:0] REG_COMMAND = 4'h0;
    localparam logic [3:0] REG_PINS    = 4'h4;
    localparam logic [3:0] REG_STATUS  = 4'h8;
    localparam logic [3:0] REG_MASK_WR = 4'hc;

    // Controller field positions
    localparam int CMD_ADDR_LSB   = 8;
    localparam int CMD_WRITE_BIT  = 16;
    localparam int PINS_CA_LSB    = 8;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_REFUSED   = 1;
    localparam int STAT_READ_LSB  = 8;
    localparam int STAT_DQ_LSB    = 16;
    localparam int STAT_MON_BIT   = 24;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        CTL_IDLE  = 2'b00,
        CTL_ISSUE = 2'b01,
        CTL_WAIT  = 2'b10
    } ctl_state_e;

endpackage

// *** core/mode_link_if.sv ***
// Link between the controller end and the device end.
// Assumes both ends share aclk.
`timescale 1ns/1ps
interface mode_link_if;
    // Command side, driven by the controller
    logic       cmd_valid;
    logic       cmd_write;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_op;
    logic       cke;
    logic [5:0] ca;
    logic       mask_wr_valid;
    // Answer side, driven by the device
    logic [7:0] dq;
    logic       dq_valid;
    logic       vref_mon_valid;
    logic [6:0] vref_mon_cmd;
    logic [6:0] vref_mon_data;

    modport device
    (
        input  cmd_valid, cmd_write, cmd_addr, cmd_op, cke, ca, mask_wr_valid,
        output dq, dq_valid, vref_mon_valid, vref_mon_cmd, vref_mon_data
    );
    modport ctrl
    (
        output cmd_valid, cmd_write, cmd_addr, cmd_op, cke, ca, mask_wr_valid,
        input  dq, dq_valid, vref_mon_valid, vref_mon_cmd, vref_mon_data
    );
endinterface

// *** core/dram_fsp_mode_regs.sv ***
// Device end: operating-point control and data reference registers with
// their two set-point copies, training echo and refresh-code filtering.
// Assumes commands arrive one per cycle, synchronous to aclk.
`timescale 1ns/1ps
module dram_fsp_mode_regs
    import fsp_mode_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Link to the controller
    mode_link_if.device     link,
    // Device-internal inputs
    input  wire logic       capability_bit,
    input  wire logic [2:0] raw_refresh_code,
    input  wire logic [6:0] cmd_ref_voltage_sp0,
    input  wire logic [6:0] cmd_ref_voltage_sp1,
    // Mode outputs
    output logic            cmd_bus_train,
    output logic            read_preamble_train,
    output logic            ref_level_output,
    output logic            ref_fast_settle,
    output logic            mask_disable,
    output logic            write_set_point_sel,
    output logic            operate_set_point_sel,
    // Active data reference
    output logic [5:0]      active_data_ref_level,
    output logic            active_data_ref_range,
    output logic            active_level_reserved,
    // Refresh status and write masking
    output logic [2:0]      refresh_rate_status_reg,
    output logic            mask_apply,
    output logic            mask_illegal
);

    logic [7:0] op_ctrl;
    logic [6:0] data_ref [2];
    logic [7:0] dq_q;
    logic       dq_valid_q;
    logic       mon_valid_q;
    logic [6:0] mon_cmd_q;
    logic [6:0] mon_data_q;
    logic [2:0] refresh_q;
    logic       mask_apply_q;
    logic       mask_illegal_q;

    logic [7:0] next_op_ctrl;
    logic [6:0] next_data_ref [2];
    logic [7:0] next_dq;
    logic       next_dq_valid;
    logic       next_mon_valid;
    logic [6:0] next_mon_cmd;
    logic [6:0] next_mon_data;
    logic [2:0] next_refresh;
    logic       next_mask_apply;
    logic       next_mask_illegal;

    logic       training_hold;
    logic       wr_sel;
    logic       op_sel;

    // Decoded control fields
    assign training_hold = op_ctrl[BIT_CMD_BUS_TRAIN] && !link.cke;
    assign wr_sel        = op_ctrl[BIT_WRITE_SP_SEL];
    assign op_sel        = op_ctrl[BIT_OPERATE_SP_SEL];

    // Register writes and read answers
    always_comb
    begin
        next_op_ctrl     = op_ctrl;
        next_data_ref[0] = data_ref[0];
        next_data_ref[1] = data_ref[1];
        next_dq          = 8'h00;
        next_dq_valid    = 1'b0;
        if (training_hold)
        begin
            // Commands dropped, CA echoed on DQ
            next_dq       = {2'b00, link.ca};
            next_dq_valid = 1'b1;
        end
        else if (link.cmd_valid)
        begin
            if (link.cmd_write)
            begin
                case (link.cmd_addr)
                    ADDR_OP_CONTROL:
                    begin
                        next_op_ctrl = link.cmd_op;
                    end
                    ADDR_DATA_REF:
                    begin
                        // Write-selected copy only; reserved codes kept
                        next_data_ref[wr_sel] = link.cmd_op[6:0];
                    end
                    default:
                    begin
                        next_op_ctrl = op_ctrl;
                    end
                endcase
            end
            else
            begin
                next_dq_valid = 1'b1;
                case (link.cmd_addr)
                    ADDR_DATA_REF:
                    begin
                        next_dq = {1'b0, data_ref[wr_sel]};
                    end
                    ADDR_REFRESH_STAT:
                    begin
                        next_dq = {5'b00000, refresh_q};
                    end
                    ADDR_CAPABILITY:
                    begin
                        next_dq = {7'b0000000, capability_bit};
                    end
                    default:
                    begin
                        // Write-only and unmapped read zero
                        next_dq = 8'h00;
                    end
                endcase
            end
        end
    end

    // Monitor, refresh filter and mask decisions
    always_comb
    begin
        next_mon_valid = op_ctrl[BIT_REF_LEVEL_OUT];
        next_mon_cmd   = 7'h00;
        next_mon_data  = 7'h00;
        if (op_ctrl[BIT_REF_LEVEL_OUT])
        begin
            // Operating set point only
            next_mon_cmd  = op_sel ? cmd_ref_voltage_sp1 : cmd_ref_voltage_sp0;
            next_mon_data = data_ref[op_sel];
        end
        next_refresh = raw_refresh_code;
        if (capability_bit && !op_ctrl[BIT_REFRESH_OPTION] &&
            (raw_refresh_code == REFRESH_CODE_A || raw_refresh_code == REFRESH_CODE_B))
        begin
            next_refresh = REFRESH_CODE_SUB;
        end
        next_mask_apply   = link.mask_wr_valid && !op_ctrl[BIT_MASK_DISABLE];
        next_mask_illegal = link.mask_wr_valid && op_ctrl[BIT_MASK_DISABLE];
    end

    // State registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            op_ctrl        <= OP_CONTROL_RESET;
            data_ref[0]    <= DATA_REF_RESET;
            data_ref[1]    <= DATA_REF_RESET;
            dq_q           <= 8'h00;
            dq_valid_q     <= 1'b0;
            mon_valid_q    <= 1'b0;
            mon_cmd_q      <= 7'h00;
            mon_data_q     <= 7'h00;
            refresh_q      <= 3'h0;
            mask_apply_q   <= 1'b0;
            mask_illegal_q <= 1'b0;
        end
        else
        begin
            op_ctrl        <= next_op_ctrl;
            data_ref[0]    <= next_data_ref[0];
            data_ref[1]    <= next_data_ref[1];
            dq_q           <= next_dq;
            dq_valid_q     <= next_dq_valid;
            mon_valid_q    <= next_mon_valid;
            mon_cmd_q      <= next_mon_cmd;
            mon_data_q     <= next_mon_data;
            refresh_q      <= next_refresh;
            mask_apply_q   <= next_mask_apply;
            mask_illegal_q <= next_mask_illegal;
        end
    end

    // Link answers
    assign link.dq             = dq_q;
    assign link.dq_valid       = dq_valid_q;
    assign link.vref_mon_valid = mon_valid_q;
    assign link.vref_mon_cmd   = mon_cmd_q;
    assign link.vref_mon_data  = mon_data_q;

    // Mode outputs
    assign cmd_bus_train         = op_ctrl[BIT_CMD_BUS_TRAIN];
    assign read_preamble_train   = op_ctrl[BIT_READ_PRE_TRAIN];
    assign ref_level_output      = op_ctrl[BIT_REF_LEVEL_OUT];
    assign ref_fast_settle       = op_ctrl[BIT_REF_FAST];
    assign mask_disable          = op_ctrl[BIT_MASK_DISABLE];
    assign write_set_point_sel   = wr_sel;
    assign operate_set_point_sel = op_sel;

    // Inactive copy may be rewritten freely
    assign active_data_ref_level = data_ref[op_sel][5:0];
    assign active_data_ref_range = data_ref[op_sel][BIT_DATA_REF_RANGE];
    assign active_level_reserved = data_ref[op_sel][5:0] > LEVEL_CODE_MAX;

    assign refresh_rate_status_reg = refresh_q;
    assign mask_apply              = mask_apply_q;
    assign mask_illegal            = mask_illegal_q;

endmodule

// *** core/mode_cmd_controller.sv ***
// Controller end: an AXI4-Lite slave whose registers issue mode register
// writes and reads, drive CKE and CA, and issue masked writes.
// Assumes the device end answers a read on the cycle after the command.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module mode_cmd_controller
    import fsp_mode_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Link to the device
    mode_link_if.ctrl        link
);

    ctl_state_e  state, next_state;
    logic [16:0] cmd_word, next_cmd_word;
    logic        cke_q, next_cke;
    logic [5:0]  ca_q, next_ca;
    logic [7:0]  shadow, next_shadow;
    logic [7:0]  read_data, next_read_data;
    logic [7:0]  dq_seen, next_dq_seen;
    logic        refused, next_refused;
    logic        mask_q, next_mask;
    logic        bvalid_q, next_bvalid;
    logic [1:0]  bresp_q, next_bresp;
    logic        rvalid_q, next_rvalid;
    logic [31:0] rdata_q, next_rdata;
    logic [1:0]  rresp_q, next_rresp;
    logic        wr_take;
    logic        rd_take;
    logic        hold;
    logic        bad;
    logic        clr_ok;

    // Both write channels are taken together, one write in flight
    assign wr_take = awvalid && wvalid && !bvalid_q;
    assign rd_take = arvalid && !rvalid_q;
    assign awready = wr_take;
    assign wready  = wr_take;
    assign arready = rd_take;
    assign hold    = shadow[BIT_CMD_BUS_TRAIN] && !cke_q;

    // Registers, sequencing and bus answers
    always_comb
    begin
        next_state     = state;
        next_cmd_word  = cmd_word;
        next_cke       = cke_q;
        next_ca        = ca_q;
        next_shadow    = shadow;
        next_read_data = read_data;
        next_dq_seen   = link.dq_valid ? link.dq : dq_seen;
        next_mask      = 1'b0;
        next_bvalid    = bvalid_q && !bready;
        next_bresp     = bresp_q;
        next_rvalid    = rvalid_q && !rready;
        next_rdata     = rdata_q;
        next_rresp     = rresp_q;
        bad            = 1'b0;
        clr_ok         = wr_take && awaddr == REG_STATUS && wstrb[0] && wdata[STAT_REFUSED];
        next_refused   = refused && !clr_ok;
        case (state)
            CTL_ISSUE:
            begin
                next_state = cmd_word[CMD_WRITE_BIT] ? CTL_IDLE : CTL_WAIT;
            end
            CTL_WAIT:
            begin
                if (link.dq_valid)
                begin
                    next_read_data = link.dq;
                    next_state     = CTL_IDLE;
                end
            end
            default:
            begin
                next_state = CTL_IDLE;
            end
        endcase
        if (wr_take)
        begin
            next_bvalid = 1'b1;
            next_bresp  = RESP_OKAY;
            case (awaddr)
                REG_COMMAND:
                begin
                    // Refused while busy or held in training
                    if (state != CTL_IDLE || hold)
                    begin
                        bad = 1'b1;
                    end
                    else
                    begin
                        // Level and range always travel in the same byte
                        next_cmd_word = {wdata[CMD_WRITE_BIT], 2'b00, wdata[13:0]};
                        next_state    = CTL_ISSUE;
                        if (wdata[CMD_WRITE_BIT] && wdata[CMD_ADDR_LSB +: 6] == ADDR_OP_CONTROL)
                        begin
                            next_shadow = wdata[7:0];
                        end
                    end
                end
                REG_PINS:
                begin
                    next_cke = wdata[0];
                    next_ca  = wdata[PINS_CA_LSB +: 6];
                end
                REG_MASK_WR:
                begin
                    if (shadow[BIT_MASK_DISABLE])
                    begin
                        bad = 1'b1;
                    end
                    else
                    begin
                        next_mask = 1'b1;
                    end
                end
                REG_STATUS: next_bresp = RESP_OKAY;
                default:
                begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        // A refusal in the clearing cycle still sets the flag
        if (bad)
        begin
            next_refused = 1'b1;
        end
        if (rd_take)
        begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (araddr)
                REG_COMMAND: next_rdata = {15'h0000, cmd_word};
                REG_PINS:    next_rdata = {18'h00000, ca_q, 7'h00, cke_q};
                REG_STATUS:  next_rdata = {7'h00, link.vref_mon_valid, dq_seen, read_data, 6'h00,
                                           refused, state != CTL_IDLE};
                REG_MASK_WR: next_rdata = 32'h00000000;
                default:
                begin
                    next_rdata = 32'h00000000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Registers only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state     <= CTL_IDLE;
            cmd_word  <= 17'h00000;
            cke_q     <= 1'b1;
            ca_q      <= 6'h00;
            shadow    <= OP_CONTROL_RESET;
            read_data <= 8'h00;
            dq_seen   <= 8'h00;
            refused   <= 1'b0;
            mask_q    <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= RESP_OKAY;
        end
        else
        begin
            state     <= next_state;
            cmd_word  <= next_cmd_word;
            cke_q     <= next_cke;
            ca_q      <= next_ca;
            shadow    <= next_shadow;
            read_data <= next_read_data;
            dq_seen   <= next_dq_seen;
            refused   <= next_refused;
            mask_q    <= next_mask;
            bvalid_q  <= next_bvalid;
            bresp_q   <= next_bresp;
            rvalid_q  <= next_rvalid;
            rdata_q   <= next_rdata;
            rresp_q   <= next_rresp;
        end
    end

    assign bvalid             = bvalid_q;
    assign bresp              = bresp_q;
    assign rvalid             = rvalid_q;
    assign rdata              = rdata_q;
    assign rresp              = rresp_q;
    assign link.cmd_valid     = (state == CTL_ISSUE);
    assign link.cmd_write     = cmd_word[CMD_WRITE_BIT];
    assign link.cmd_addr      = cmd_word[13:8];
    assign link.cmd_op        = cmd_word[7:0];
    assign link.cke           = cke_q;
    assign link.ca            = ca_q;
    assign link.mask_wr_valid = mask_q;

endmodule

// *** bench/fsp_link_sva.sv ***
// Checker for the controller-to-device link.
// Assumes one aclk domain and a synchronous active-low aresetn.
`timescale 1ns/1ps
module fsp_link_sva
    import fsp_mode_pkg::*;
(
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Command side
    input wire logic       cmd_valid,
    input wire logic       cmd_write,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_op,
    input wire logic       cke,
    input wire logic [5:0] ca,
    input wire logic       mask_wr_valid,
    // Answer side
    input wire logic [7:0] dq,
    input wire logic       dq_valid,
    input wire logic       vref_mon_valid,
    input wire logic [6:0] vref_mon_cmd,
    input wire logic [6:0] vref_mon_data
);
    logic [7:0] shadow;
    logic [7:0] next_shadow;
    logic       held;
    logic       next_held;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Control register as the device sees it
    always_comb
    begin
        next_shadow = shadow;
        next_held = shadow[BIT_CMD_BUS_TRAIN] && !cke;
        if (cmd_valid && cmd_write && cmd_addr == ADDR_OP_CONTROL && !next_held)
            next_shadow = cmd_op;
    end
    always_ff @(posedge aclk)
    begin
        shadow <= aresetn ? next_shadow : OP_CONTROL_RESET;
        held <= aresetn ? next_held : 1'b0;
    end
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> cke && !cmd_valid && !dq_valid)
        else $error("link not idle after reset");
    AST_DREF_READ: assert property (cmd_valid && !cmd_write && cmd_addr == ADDR_DATA_REF && cke
        |=> dq_valid && !dq[7]) else $error("data reference read wrong");
    AST_CTRL_READ: assert property (cmd_valid && !cmd_write && cmd_addr == ADDR_OP_CONTROL && cke
        |=> dq_valid && dq == 8'h00) else $error("control register readable");
    AST_REF_OUT: assert property (cmd_valid && cmd_write && cmd_addr == ADDR_OP_CONTROL && cke
        |-> ##2 vref_mon_valid == shadow[BIT_REF_LEVEL_OUT]) else $error("reference output mode wrong");
    AST_REF_QUIET: assert property (!vref_mon_valid |-> vref_mon_cmd == 7'h00 && vref_mon_data == 7'h00)
        else $error("reference levels shown while off");
    AST_TRAIN_ECHO: assert property (held && shadow[BIT_CMD_BUS_TRAIN] && !cke
        |-> dq_valid && dq == {2'b00, $past(ca)}) else $error("training echo wrong");
    AST_HOLD_NO_CMD: assert property (cmd_valid |-> cke || !shadow[BIT_CMD_BUS_TRAIN])
        else $error("command sent with training bus held");
    AST_NO_MASKED: assert property (mask_wr_valid |-> !shadow[BIT_MASK_DISABLE])
        else $error("masked write while masking off");
    // Main scenarios
    cover property (cmd_valid && cmd_write && cmd_addr == ADDR_DATA_REF);
    cover property (held);
    cover property (vref_mon_valid);
endmodule

// *** bench/tb_top.sv ***
// Bench joining both ends through the link interface.
// Assumes the controller answers every AXI4-Lite request.
`timescale 1ns/1ps
module tb_top;
    import fsp_mode_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, capability_bit;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] wdata, rdata, st;
    logic [2:0]  raw_refresh_code, refresh_rate_status_reg, ex;
    logic [6:0]  sp0, sp1, mode_bits;
    logic [5:0]  lvl;
    logic        rng, rsv, mask_apply, mask_illegal;
    int          failures, samples_checked, applied, illegal;
    mode_link_if link();
    mode_cmd_controller i_mode_cmd_controller (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
    dram_fsp_mode_regs i_dram_fsp_mode_regs (.aclk(aclk), .aresetn(aresetn), .link(link),
        .capability_bit(capability_bit), .raw_refresh_code(raw_refresh_code), .cmd_ref_voltage_sp0(sp0),
        .cmd_ref_voltage_sp1(sp1), .cmd_bus_train(mode_bits[0]), .read_preamble_train(mode_bits[1]),
        .ref_level_output(mode_bits[2]), .ref_fast_settle(mode_bits[3]), .mask_disable(mode_bits[4]),
        .write_set_point_sel(mode_bits[5]), .operate_set_point_sel(mode_bits[6]), .active_data_ref_level(lvl),
        .active_data_ref_range(rng), .active_level_reserved(rsv), .refresh_rate_status_reg(refresh_rate_status_reg),
        .mask_apply(mask_apply), .mask_illegal(mask_illegal));
    fsp_link_sva i_fsp_link_sva (.aclk(aclk), .aresetn(aresetn), .cmd_valid(link.cmd_valid),
        .cmd_write(link.cmd_write), .cmd_addr(link.cmd_addr), .cmd_op(link.cmd_op), .cke(link.cke), .ca(link.ca),
        .mask_wr_valid(link.mask_wr_valid), .dq(link.dq), .dq_valid(link.dq_valid),
        .vref_mon_valid(link.vref_mon_valid), .vref_mon_cmd(link.vref_mon_cmd), .vref_mon_data(link.vref_mon_data));
    // Mask answers are one-cycle pulses
    always @(posedge aclk) if (mask_apply === 1'b1) applied++;
    always @(posedge aclk) if (mask_illegal === 1'b1) illegal++;
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Both taken together; answer follows
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        chk(bresp, RESP_OKAY);
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        st = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Mode register command, poll till idle
    task mr(input logic w, input logic [5:0] a, input logic [7:0] op);
        wr(REG_COMMAND, {15'h0, w, 2'h0, a, op});
        do rd(REG_STATUS);
        while (st[STAT_BUSY_BIT] !== 1'b0);
    endtask
    task t_reset();
        chk({rng, lvl, mode_bits}, 14'h26_80);
        mr(1'b0, ADDR_DATA_REF, 8'h00);
        chk(st[15:8], 8'h4d);
        mr(1'b0, ADDR_OP_CONTROL, 8'h00);
        chk(st[15:8], 8'h00);
        rd(4'h2);
        chk({rs, st[7:0]}, {RESP_SLVERR, 8'h00});
    endtask
    task t_bits();
        for (int i = 0; i < 8; i++)
        begin
            mr(1'b1, ADDR_OP_CONTROL, 8'h01 << i);
            chk({st[STAT_MON_BIT], mode_bits[3:0]}, {i == 2, 4'(i < 4) << i});
            chk(mode_bits[6:4], 3'(i > 4) << (i - 5));
        end
    endtask
    task t_setpoint();
        mr(1'b1, ADDR_OP_CONTROL, 8'h40);
        mr(1'b1, ADDR_DATA_REF, 8'h25);
        mr(1'b0, ADDR_DATA_REF, 8'h00);
        chk({st[15:8], rng, lvl}, {8'h25, DATA_REF_RESET});
        mr(1'b1, ADDR_OP_CONTROL, 8'h84);
        mr(1'b0, ADDR_DATA_REF, 8'h00);
        chk({st[15:8], rng, lvl}, 15'h26a5);
        chk({link.vref_mon_data, link.vref_mon_cmd}, {7'h25, sp1});
        mr(1'b1, ADDR_DATA_REF, 8'h7f);
        mr(1'b0, ADDR_DATA_REF, 8'h00);
        chk({st[15:8], rsv, mode_bits}, 16'h7f44);
        mr(1'b1, ADDR_OP_CONTROL, 8'h00);
        chk({rsv, lvl}, 7'h7f);
    endtask
    task t_refresh();
        for (int k = 0; k < 12; k++)
        begin
            mr(1'b1, ADDR_OP_CONTROL, {3'h0, k[1], 4'h0});
            capability_bit <= k[0];
            raw_refresh_code <= 3'(k / 4 + 1);
            ex = (k % 4 == 1 && k < 8) ? REFRESH_CODE_SUB : 3'(k / 4 + 1);
            repeat (3) @(posedge aclk);
            chk(refresh_rate_status_reg, ex);
        end
    endtask
    task t_train_mask();
        mr(1'b1, ADDR_OP_CONTROL, 8'h01);
        wr(REG_PINS, 32'h2a00);
        repeat (4) @(posedge aclk);
        wr(REG_COMMAND, 32'h10d00);
        rd(REG_STATUS);
        chk({st[23:16], st[STAT_REFUSED], mode_bits[0]}, 10'h0ab);
        wr(REG_PINS, 32'h1);
        mr(1'b1, ADDR_OP_CONTROL, 8'h00);
        wr(REG_STATUS, 32'h2);
        wr(REG_MASK_WR, 32'h0);
        mr(1'b1, ADDR_OP_CONTROL, 8'h20);
        wr(REG_MASK_WR, 32'h0);
        rd(REG_STATUS);
        chk({applied[7:0], illegal[7:0], st[STAT_REFUSED], mode_bits[0]}, {8'h1, 8'h0, 2'b10});
    endtask
    task wrap_up();
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog, 20000 cycles
    initial
    begin
        #(25 * 20000);
        failures++;
        wrap_up();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, capability_bit} = 7'h00;
        {awaddr, araddr, wdata, raw_refresh_code} = 43'h0;
        wstrb = 4'hf;
        sp0 = 7'h11;
        sp1 = 7'h5a;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bits();
        t_setpoint();
        t_refresh();
        t_train_mask();
        wrap_up();
    end
endmodule
